// File: rtl/table_write_instr.v
// Behaviour
// - Decode one fixed 16-bit opcode; low two bits pick pointer mode 0..3.
// - Pointer bit zero picks low byte (0) or high byte (1) of word.
// - Instruction is one word and takes two instruction cycles.
// - Second cycle: read latch in Q2, write holding register in Q4.
// - No arithmetic status flag changes in any pointer mode.
// - Post modes adjust pointer after write; pre-increment adjusts before.
`timescale 1ns/1ps
`include "table_write_regs.vh"

module table_write_instr #(
    parameter PTR_W = `TW_PTR_WIDTH
) (
    input wire i_core_clk,                 // Processor clock
    input wire i_rst_n,                    // Async reset, active low
    input wire [15:0] i_opcode,            // Fetched instruction word
    input wire i_decode,                   // Pulse: opcode valid in Q1 decode
    input wire [1:0] i_quarter,            // Current quarter of the cycle
    input wire [7:0] i_table_latch,        // Table latch contents
    input wire i_ptr_load,                 // Pulse: software load of pointer
    input wire [PTR_W-1:0] i_ptr_load_val, // Value for pointer load
    output reg o_busy,                     // High during the two cycles
    output reg o_done,                     // Pulse at completion
    output reg [PTR_W-1:0] o_table_pointer, // Table pointer
    output reg o_hold_we,                  // Pulse: holding register write
    output reg [PTR_W-2:0] o_hold_word,    // Program word address
    output reg o_hold_byte_hi,             // Byte select: 1 = high byte
    output reg [7:0] o_hold_data,          // Byte to holding register
    output reg o_flags_we,                 // Status flag write, always low
    output reg o_commit                    // Array commit request, always low
);
    localparam ST_IDLE = 2'h0;
    localparam ST_DEC = 2'h1;
    localparam ST_XFER = 2'h2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] mode_r;
    reg [1:0] mode_nxt;
    reg [7:0] latch_r;
    reg [7:0] latch_nxt;
    reg [PTR_W-1:0] ptr_nxt;
    reg busy_nxt;
    reg done_nxt;
    reg hold_we_nxt;
    reg [PTR_W-2:0] hold_word_nxt;
    reg hold_byte_hi_nxt;
    reg [7:0] hold_data_nxt;
    wire [PTR_W-1:0] addr_w;
    wire [PTR_W-1:0] next_w;
    wire hit_w;
    wire dec_end_w;
    wire latch_slot_w;
    wire write_slot_w;
    wire load_ok_w;

    // Upper fourteen bits fixed; the mode field is a don't-care for the match
    function is_table_write;
        input [15:0] op_word;
        begin
            is_table_write = ((op_word & `TW_OPCODE_MASK) == `TW_OPCODE_BASE);
        end
    endfunction

    function in_quarter;
        input [1:0] qtr;
        input [1:0] want;
        begin
            in_quarter = (qtr == want);
        end
    endfunction

    assign hit_w = i_decode && is_table_write(i_opcode);
    // Quarters count from the core's decode; a decode pulsed in Q2 or Q3 would shorten
    // the first cycle and one in Q4 would stretch it, so the core must only raise i_decode in Q1
    assign dec_end_w = (state_r == ST_DEC) && in_quarter(i_quarter, `TW_Q4);
    assign latch_slot_w = (state_r == ST_XFER) && in_quarter(i_quarter, `TW_Q2);
    assign write_slot_w = (state_r == ST_XFER) && in_quarter(i_quarter, `TW_Q4);
    // A software load loses to a table write taken on the same edge
    assign load_ok_w = (state_r == ST_IDLE) && !hit_w && i_ptr_load;

    table_ptr_step #(
        .PTR_W(PTR_W)
    ) u_step (
        .i_ptr(o_table_pointer),
        .i_mode(mode_r),
        .o_addr(addr_w),
        .o_next(next_w)
    );

    // Control path: which of the two instruction cycles is running
    always @*
    begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        busy_nxt = o_busy;
        case (state_r)
            ST_IDLE:
            begin
                if (hit_w)
                begin
                    mode_nxt = i_opcode[`TW_MODE_MSB:`TW_MODE_LSB];
                    state_nxt = ST_DEC;
                    busy_nxt = 1'h1;
                end
            end
            ST_DEC:
            begin
                // Decode cycle ends at Q4; transfer cycle starts next
                if (dec_end_w)
                begin
                    state_nxt = ST_XFER;
                end
            end
            ST_XFER:
            begin
                if (write_slot_w)
                begin
                    state_nxt = ST_IDLE;
                    busy_nxt = 1'h0;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
                busy_nxt = 1'h0;
            end
        endcase
    end

    // Latch byte is captured once in Q2 and held, so a later change is not seen
    always @*
    begin
        latch_nxt = latch_r;
        if (latch_slot_w)
        begin
            latch_nxt = i_table_latch;
        end
    end

    always @*
    begin
        ptr_nxt = o_table_pointer;
        if (write_slot_w)
        begin
            ptr_nxt = next_w;
        end
        else if (load_ok_w)
        begin
            ptr_nxt = i_ptr_load_val;
        end
    end

    // Address, byte lane and data stay put after the strobe for the holding side
    always @*
    begin
        hold_we_nxt = 1'h0;
        done_nxt = 1'h0;
        hold_word_nxt = o_hold_word;
        hold_byte_hi_nxt = o_hold_byte_hi;
        hold_data_nxt = o_hold_data;
        if (write_slot_w)
        begin
            hold_we_nxt = 1'h1;
            done_nxt = 1'h1;
            hold_data_nxt = latch_r;
            hold_word_nxt = addr_w[PTR_W-1:1];
            hold_byte_hi_nxt = addr_w[0];
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= ST_IDLE;
            mode_r <= `TW_MODE_NONE;
            o_busy <= 1'h0;
            o_done <= 1'h0;
        end
        else
        begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            o_busy <= busy_nxt;
            o_done <= done_nxt;
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            latch_r <= 8'h00;
            o_table_pointer <= `TW_PTR_RESET;
            o_hold_we <= 1'h0;
            o_hold_word <= {(PTR_W-1){1'h0}};
            o_hold_byte_hi <= 1'h0;
            o_hold_data <= 8'h00;
        end
        else
        begin
            latch_r <= latch_nxt;
            o_table_pointer <= ptr_nxt;
            o_hold_we <= hold_we_nxt;
            o_hold_word <= hold_word_nxt;
            o_hold_byte_hi <= hold_byte_hi_nxt;
            o_hold_data <= hold_data_nxt;
        end
    end

    // Flags and array commit are never touched by this instruction; the strobes
    // are kept as firm lows so the core's flag and flash paths see no glitch
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_flags_we <= 1'h0;
            o_commit <= 1'h0;
        end
        else
        begin
            o_flags_we <= 1'h0;
            o_commit <= 1'h0;
        end
    end
endmodule

// File: rtl/table_write_regs.vh
`ifndef TABLE_WRITE_REGS_VH
`define TABLE_WRITE_REGS_VH

// Opcode layout: upper 14 bits fixed, low 2 bits select pointer mode
`define TW_OPCODE_MASK 16'hfffc
`define TW_OPCODE_BASE 16'h000c
`define TW_MODE_MSB 1
`define TW_MODE_LSB 0

// Pointer modes
`define TW_MODE_NONE 2'h0
`define TW_MODE_POSTINC 2'h1
`define TW_MODE_POSTDEC 2'h2
`define TW_MODE_PREINC 2'h3

// Pointer width and reset value
`define TW_PTR_WIDTH 21
`define TW_PTR_RESET 21'h00_0000

// Quarter-cycle phases within an instruction cycle
`define TW_Q1 2'h0
`define TW_Q2 2'h1
`define TW_Q3 2'h2
`define TW_Q4 2'h3

// Instruction length
`define TW_WORDS 1
`define TW_CYCLES 2

`endif

// File: rtl/table_ptr_step.v
`timescale 1ns/1ps
`include "table_write_regs.vh"

// Computes the pointer value used for the write and the value stored after it
module table_ptr_step #(
    parameter PTR_W = `TW_PTR_WIDTH
) (
    input wire [PTR_W-1:0] i_ptr,     // Pointer before execution
    input wire [1:0] i_mode,          // Pointer mode field
    output reg [PTR_W-1:0] o_addr,    // Address used for the write
    output reg [PTR_W-1:0] o_next     // Pointer after execution
);
    localparam [PTR_W-1:0] ONE = {{(PTR_W-1){1'b0}}, 1'b1};

    // Shared by post-increment and pre-increment; wraps at the pointer width
    function [PTR_W-1:0] ptr_inc;
        input [PTR_W-1:0] ptr;
        begin
            ptr_inc = ptr + ONE;
        end
    endfunction

    always @*
    begin
        o_addr = i_ptr;
        o_next = i_ptr;
        case (i_mode)
            `TW_MODE_POSTINC:
            begin
                o_next = ptr_inc(i_ptr);
            end
            `TW_MODE_POSTDEC:
            begin
                o_next = i_ptr - ONE;
            end
            `TW_MODE_PREINC:
            begin
                o_addr = ptr_inc(i_ptr);
                o_next = ptr_inc(i_ptr);
            end
            default:
            begin
                o_next = i_ptr;
            end
        endcase
    end
endmodule

// File: testbench/tw_props.sv
`timescale 1ns/1ps
module tw_props (
    input wire i_core_clk, // Clock
    input wire i_rst_n, // Reset
    input wire [15:0] i_opcode, // Word
    input wire i_decode, // Decode
    input wire i_ptr_load, // Load
    input wire o_busy, // Busy
    input wire o_done, // Done
    input wire [20:0] o_table_pointer, // Pointer
    input wire o_hold_we, // Write
    input wire o_flags_we, // Flags
    input wire o_commit // Commit
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    wire hit = (i_opcode & 16'hfffc) == 16'h000c;
    wire load_ok = i_ptr_load && !o_busy && !(i_decode && hit);
    sequence s_go; i_decode && !o_busy && hit; endsequence
    sequence s_run; o_busy [*7] ##1 !o_busy; endsequence
    a_we_time: assert property (s_go |=> !o_hold_we [*7] ##1 o_hold_we)
        else $error("late");
    a_busy_span: assert property (s_go |=> s_run) else $error("busy");
    a_done_we: assert property (o_done == o_hold_we) else $error("done");
    a_bad_op: assert property (i_decode && !o_busy && !hit |=> !o_busy) else $error("op");
    a_ptr_cause: assert property ($changed(o_table_pointer) |-> o_done || $past(load_ok))
        else $error("ptr");
    a_no_flags: assert property (!o_flags_we) else $error("flags");
    a_no_commit: assert property (!o_commit) else $error("commit");
endmodule
bind table_write_instr tw_props u_tw_props (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_opcode(i_opcode),
    .i_decode(i_decode),
    .i_ptr_load(i_ptr_load),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_table_pointer(o_table_pointer),
    .o_hold_we(o_hold_we),
    .o_flags_we(o_flags_we),
    .o_commit(o_commit)
);

// File: testbench/hold_regs.sv
`timescale 1ns/1ps
module hold_regs (
    input wire i_core_clk, // Clock
    input wire i_hold_we, // Write pulse
    input wire i_hold_byte_hi, // Byte select
    input wire [7:0] i_hold_data, // Byte
    output reg [15:0] o_held // Held word
);
    // One word only: enough to see both byte lanes land
    always @(posedge i_core_clk)
    begin
        if (i_hold_we && i_hold_byte_hi)
        begin
            o_held[15:8] <= i_hold_data;
        end
        else if (i_hold_we)
        begin
            o_held[7:0] <= i_hold_data;
        end
    end
endmodule

// File: testbench/table_write_instr_bench.sv
`timescale 1ns/1ps
module table_write_instr_bench;
    reg i_core_clk = 0, i_rst_n = 0, i_decode = 0, i_ptr_load = 0;
    reg [15:0] i_opcode = 16'h0;
    reg [1:0] i_quarter = 2'h0;
    reg [7:0] i_table_latch = 8'h0;
    reg [20:0] i_ptr_load_val = 21'h0;
    wire o_busy, o_done, o_hold_we, o_hold_byte_hi, o_flags_we, o_commit;
    wire [20:0] o_table_pointer;
    wire [19:0] o_hold_word;
    wire [7:0] o_hold_data;
    wire [15:0] held;
    integer miscompares = 0, comparisons = 0;
    table_write_instr u_table_write_instr (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_opcode(i_opcode),
        .i_decode(i_decode),
        .i_quarter(i_quarter),
        .i_table_latch(i_table_latch),
        .i_ptr_load(i_ptr_load),
        .i_ptr_load_val(i_ptr_load_val),
        .o_busy(o_busy),
        .o_done(o_done),
        .o_table_pointer(o_table_pointer),
        .o_hold_we(o_hold_we),
        .o_hold_word(o_hold_word),
        .o_hold_byte_hi(o_hold_byte_hi),
        .o_hold_data(o_hold_data),
        .o_flags_we(o_flags_we),
        .o_commit(o_commit)
    );
    hold_regs u_hold_regs (
        .i_core_clk(i_core_clk),
        .i_hold_we(o_hold_we),
        .i_hold_byte_hi(o_hold_byte_hi),
        .i_hold_data(o_hold_data),
        .o_held(held)
    );
    initial
        forever #25 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) i_quarter <= #1 i_quarter + 2'h1;
    task chk(input bit ok);
    begin
        comparisons = comparisons + 1;
        if (!ok)
        begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: mismatch", $time);
        end
    end
    endtask
    task stop_test;
    begin
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task run(input [15:0] op, input [7:0] d, input [20:0] p, pe, a);
    begin
        i_ptr_load = 1;
        i_ptr_load_val = p;
        @(posedge i_core_clk) #1 i_ptr_load = 0;
        // Quarter moves 1 ns after each edge, so it is read on the edge itself
        @(posedge i_core_clk);
        while (i_quarter !== 2'h3)
            @(posedge i_core_clk);
        #1 i_decode = 1;
        i_opcode = op;
        i_table_latch = d;
        @(posedge i_core_clk) #1 i_decode = 0;
        // A pointer load while busy has to be refused
        i_ptr_load = 1;
        i_ptr_load_val = ~p;
        @(posedge i_core_clk) #1 i_ptr_load = 0;
        repeat (5) @(posedge i_core_clk);
        // Latch moves after its Q2 sample, so a late read shows up
        #1 i_table_latch = ~d;
        @(posedge i_core_clk) #1;
        chk(o_hold_we === 1'b1 && o_done === 1'b1 && o_busy === 1'b0);
        @(posedge i_core_clk) #1;
        chk(o_hold_data === d && o_hold_we === 1'b0 && o_table_pointer === pe);
        chk({o_hold_word, o_hold_byte_hi} === a);
        chk(o_flags_we === 1'b0 && o_commit === 1'b0);
        @(posedge i_core_clk) #1;
    end
    endtask
    task t_modes;
    integer m;
    begin
        for (m = 0; m < 4; m = m + 1)
            run(16'h000c + m, 8'h55 + m, 21'h01_389a, 21'h01_389a + (m % 2) - (m == 2),
                21'h01_389a + (m == 3));
        chk(held === 16'h5857);
    end
    endtask
    task t_bad;
    begin
        i_opcode = 16'h800c;
        i_decode = 1;
        @(posedge i_core_clk) #1 i_decode = 0;
        @(posedge i_core_clk) #1 chk(o_busy === 1'b0);
    end
    endtask
    initial
    begin
        repeat (900) @(posedge i_core_clk);
        chk(1'b0);
        stop_test;
    end
    initial
    begin
        repeat (12) @(posedge i_core_clk);
        #1 i_rst_n = 1;
        t_modes;
        t_bad;
        stop_test;
    end
endmodule
